// ===== logic/sdi_rx_error_monitor.sv
/*
  error monitor and event counters of an sdi deserializer receive path,
  with its register bank, threshold halt and data gate.
  assumes the management-bus engine presents decoded single-cycle
  register accesses, and all event strobes and data arrive on ref_clk_i.
*/
// Notes on behaviour
// RULE1: event-select bit 3: 0 reads clock-recovery counter, 1 data counter.
// RULE2: clock-recovery counter counts recovered clock loss and pll lock loss.
// RULE3: event config bit 2 resets the clock-recovery event count.
// RULE4: event config bit 1 resets the data (link) event count.
// RULE5: both event counters count only while enable bit 0 set; resets 0.
// RULE6: accumulate bit 4 keeps error counts running across windows.
// RULE7: monitor bit 3 masks 8b10b errors from count and lock output.
// RULE8: monitor bit 2 clears current and previously held error counts.
// RULE9: monitor bit 1 selects current-run or timing-window error count.
// RULE10: monitor bit 0 keeps receiving even above the threshold.
// RULE11: above threshold the device halts and stops the parallel outputs.
// RULE12: threshold low byte 0x2e resets 0x10, high byte 0x2f resets 0x00.
// RULE13: rate bits 6:4 read 001, 011, 110 or 111 unlocked (reset).
// RULE14: an 8-bit readable count of link-loss events, reset 0.
// RULE15: data error count readable as low and high byte, reset 0.
// RULE16: reset and clear bits hold counts at zero while set.
// RULE17: counters saturate at maximum instead of wrapping.
`timescale 1ns/1ps
`default_nettype none

module sdi_rx_error_monitor
  import sdi_mon_pkg::*;
#(
  parameter int DATA_WIDTH = 10
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  input  wire reg_req_t                reg_req_i,
  output logic [`DATA_W-1:0]           reg_rdata_o,
  output logic                         reg_rvalid_o,
  input  wire rx_evt_t                 rx_evt_i,
  input  wire logic                    cdr_locked_i,
  input  wire logic [`RATE_W-1:0]      locked_rate_i,
  input  wire logic [DATA_WIDTH-1:0]   rx_data_i,
  input  wire logic                    rx_valid_i,
  output logic [DATA_WIDTH-1:0]        parallel_data_outputs_o,
  output logic                         parallel_valid_o,
  output logic                         lock_o,
  output logic                         rx_halted_o
);

  logic [`DATA_W-1:0]     evt_cfg_r;
  logic [`DATA_W-1:0]     evt_cfg_nxt;
  logic [`DATA_W-1:0]     err_mon_r;
  logic [`DATA_W-1:0]     err_mon_nxt;
  logic [`ERR_CNT_W-1:0]  thr_r;
  logic [`ERR_CNT_W-1:0]  thr_nxt;
  logic [`RATE_W-1:0]     rate_r;
  logic [`RATE_W-1:0]     rate_nxt;
  logic [`DATA_W-1:0]     rdata_r;
  logic [`DATA_W-1:0]     rdata_nxt;
  logic                   rvalid_r;
  logic                   rvalid_nxt;
  logic [`ERR_CNT_W-1:0]  win_cnt_r;
  logic [`ERR_CNT_W-1:0]  win_cnt_nxt;
  rx_state_t              state_r;
  rx_state_t              state_nxt;
  logic [DATA_WIDTH-1:0]  dout_r;
  logic [DATA_WIDTH-1:0]  dout_nxt;
  logic                   dvalid_r;
  logic                   dvalid_nxt;
  logic                   lock_r;
  logic                   lock_nxt;

  logic [`EVT_CNT_W-1:0]  cdr_cnt;
  logic [`EVT_CNT_W-1:0]  link_cnt;
  logic [`ERR_CNT_W-1:0]  run_cnt;
  logic [`ERR_CNT_W-1:0]  shown_cnt;
  logic [`EVT_CNT_W-1:0]  evt_shown;
  logic                   cnt_en;
  logic                   err_clear;
  logic                   code_err_seen;
  logic                   err_hit;
  logic                   run_restart;

  // event counters
  assign cnt_en = evt_cfg_r[`EVT_CFG_ENABLE];                       // RULE5

  sat_counter #(
    .WIDTH     (`EVT_CNT_W)
  ) u_cdr_cnt (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .clr_i     (evt_cfg_r[`EVT_CFG_RST_CDR]),                       // RULE3
    .restart_i (1'b0),
    .inc_i     (cnt_en && (rx_evt_i.clk_loss || rx_evt_i.lock_loss)), // RULE2
    .count_o   (cdr_cnt)
  );

  sat_counter #(
    .WIDTH     (`EVT_CNT_W)
  ) u_link_cnt (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .clr_i     (evt_cfg_r[`EVT_CFG_RST_LINK]),                      // RULE4
    .restart_i (1'b0),
    .inc_i     (cnt_en && rx_evt_i.link_loss),                      // RULE14
    .count_o   (link_cnt)
  );

  // error counting; masked code errors never reach the count or lock
  assign code_err_seen = rx_evt_i.code_err &&
                         !err_mon_r[`ERR_MON_CODE_MASK];            // RULE7
  assign err_hit       = rx_evt_i.data_err || code_err_seen;
  assign err_clear     = err_mon_r[`ERR_MON_CLEAR];                 // RULE8
  // without accumulate the run count starts over at each window edge
  assign run_restart   = rx_evt_i.window_tick &&
                         !err_mon_r[`ERR_MON_ACCUM];                // RULE6

  sat_counter #(
    .WIDTH     (`ERR_CNT_W)
  ) u_run_cnt (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .clr_i     (err_clear),
    .restart_i (run_restart),
    .inc_i     (err_hit),
    .count_o   (run_cnt)
  );

  assign shown_cnt = err_mon_r[`ERR_MON_SEL_WINDOW] ? win_cnt_r
                                                    : run_cnt;     // RULE9
  assign evt_shown = evt_cfg_r[`EVT_CFG_SELECT] ? link_cnt
                                                : cdr_cnt;         // RULE1

  // register bank
  always_comb
  begin
    evt_cfg_nxt = evt_cfg_r;
    err_mon_nxt = err_mon_r;
    thr_nxt     = thr_r;
    rate_nxt    = cdr_locked_i ? locked_rate_i : `RATE_UNLOCKED;   // RULE13
    rdata_nxt   = rdata_r;
    rvalid_nxt  = reg_req_i.rd;
    if (reg_req_i.wr)
    begin
      unique case (reg_req_i.addr)
        `OFS_EVT_CFG:
          evt_cfg_nxt = reg_req_i.wdata & `EVT_CFG_MASK;
        `OFS_ERR_MON:
          err_mon_nxt = reg_req_i.wdata & `ERR_MON_MASK;
        `OFS_THR_LO:
          thr_nxt[`DATA_W-1:0] = reg_req_i.wdata;                   // RULE12
        `OFS_THR_HI:
          thr_nxt[`ERR_CNT_W-1:`DATA_W] = reg_req_i.wdata;          // RULE12
        default:
          ; // counts and status take no writes
      endcase
    end
    if (reg_req_i.rd)
    begin
      unique case (reg_req_i.addr)
        `OFS_EVT_CFG:    rdata_nxt = evt_cfg_r;
        `OFS_ERR_MON:    rdata_nxt = err_mon_r;
        `OFS_THR_LO:     rdata_nxt = thr_r[`DATA_W-1:0];
        `OFS_THR_HI:     rdata_nxt = thr_r[`ERR_CNT_W-1:`DATA_W];
        `OFS_RATE:       rdata_nxt = {1'b0, rate_r, 4'h0};          // RULE13
        `OFS_EVT_COUNT:  rdata_nxt = evt_shown;                     // RULE14
        `OFS_ERR_CNT_LO: rdata_nxt = shown_cnt[`DATA_W-1:0];        // RULE15
        `OFS_ERR_CNT_HI: rdata_nxt = shown_cnt[`ERR_CNT_W-1:`DATA_W];
        default:         rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      evt_cfg_r <= `CFG_RESET;                                      // RULE5
      err_mon_r <= `CFG_RESET;
      thr_r     <= {`THR_HI_RESET, `THR_LO_RESET};                  // RULE12
      rate_r    <= `RATE_UNLOCKED;
      rdata_r   <= 8'h00;
      rvalid_r  <= 1'b0;
    end
    else
    begin
      evt_cfg_r <= evt_cfg_nxt;
      err_mon_r <= err_mon_nxt;
      thr_r     <= thr_nxt;
      rate_r    <= rate_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
    end
  end

  // window capture, halt state and data gate
  always_comb
  begin
    win_cnt_nxt = win_cnt_r;
    if (err_clear)
      win_cnt_nxt = '0;                                             // RULE8
    else if (rx_evt_i.window_tick)
      win_cnt_nxt = run_cnt;
    state_nxt = state_r;
    unique case (state_r)
      RX_NORMAL:
        if ((run_cnt > thr_r) && !err_mon_r[`ERR_MON_NO_EXIT])      // RULE10
          state_nxt = RX_HALTED;                                    // RULE11
      RX_HALTED:
        // leaves once the run count is back within the limit or bit 0 is set
        if ((run_cnt <= thr_r) || err_mon_r[`ERR_MON_NO_EXIT])
          state_nxt = RX_NORMAL;
    endcase
    dout_nxt   = dout_r;
    dvalid_nxt = 1'b0;
    if ((state_r == RX_NORMAL) && rx_valid_i)
    begin
      dout_nxt   = rx_data_i;                                       // RULE11
      dvalid_nxt = 1'b1;
    end
    lock_nxt = cdr_locked_i && !code_err_seen &&
               (state_r == RX_NORMAL);                              // RULE7
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      win_cnt_r <= '0;
      state_r   <= RX_NORMAL;
      dout_r    <= '0;
      dvalid_r  <= 1'b0;
      lock_r    <= 1'b0;
    end
    else
    begin
      win_cnt_r <= win_cnt_nxt;
      state_r   <= state_nxt;
      dout_r    <= dout_nxt;
      dvalid_r  <= dvalid_nxt;
      lock_r    <= lock_nxt;
    end
  end

  assign reg_rdata_o             = rdata_r;
  assign reg_rvalid_o            = rvalid_r;
  assign parallel_data_outputs_o = dout_r;
  assign parallel_valid_o        = dvalid_r;
  assign lock_o                  = lock_r;
  assign rx_halted_o             = (state_r == RX_HALTED);

endmodule : sdi_rx_error_monitor

`default_nettype wire

// ===== shared/sdi_mon_defs.svh
/*
  register offsets, field positions, reset values and widths of the
  receive error monitor. assumes nothing; definitions only.
*/
`ifndef SDI_MON_DEFS_SVH
`define SDI_MON_DEFS_SVH

`define ADDR_W              8
`define DATA_W              8
`define OFS_EVT_CFG         8'h2b
`define OFS_ERR_MON         8'h2d
`define OFS_THR_LO          8'h2e
`define OFS_THR_HI          8'h2f
`define OFS_RATE            8'h3b
`define OFS_EVT_COUNT       8'h3d
`define OFS_ERR_CNT_LO      8'h3e
`define OFS_ERR_CNT_HI      8'h3f

`define EVT_CFG_ENABLE      0
`define EVT_CFG_RST_LINK    1
`define EVT_CFG_RST_CDR     2
`define EVT_CFG_SELECT      3
`define EVT_CFG_MASK        8'h0f

`define ERR_MON_NO_EXIT     0
`define ERR_MON_SEL_WINDOW  1
`define ERR_MON_CLEAR       2
`define ERR_MON_CODE_MASK   3
`define ERR_MON_ACCUM       4
`define ERR_MON_MASK        8'h1f

`define THR_LO_RESET        8'h10
`define THR_HI_RESET        8'h00
`define CFG_RESET           8'h00

`define RATE_LSB            4
`define RATE_W              3
`define RATE_UNLOCKED       3'h7
`define RATE_270M           3'h1
`define RATE_1G485          3'h3
`define RATE_2G97           3'h6

`define EVT_CNT_W           8
`define ERR_CNT_W           16

`endif

// ===== shared/sdi_mon_pkg.sv
/*
  types shared by the receive error monitor files.
  assumes sdi_mon_defs.svh is on the include path.
*/
`include "sdi_mon_defs.svh"

package sdi_mon_pkg;

  // register port request, one access per cycle
  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  wdata;
  } reg_req_t;

  // single-cycle event strobes from the recovery and decode logic
  typedef struct packed {
    logic clk_loss;
    logic lock_loss;
    logic link_loss;
    logic code_err;
    logic data_err;
    logic window_tick;
  } rx_evt_t;

  typedef enum logic {
    RX_NORMAL,
    RX_HALTED
  } rx_state_t;

endpackage : sdi_mon_pkg

// ===== logic/sat_counter.sv
/*
  saturating up counter with hold-clear and restart.
  assumes inc_i, clr_i and restart_i come from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sat_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             clr_i,
  input  wire logic             restart_i,
  input  wire logic             inc_i,
  output logic [WIDTH-1:0]      count_o
);

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (clr_i)
      cnt_nxt = '0;                                 // RULE16
    else if (restart_i)
      cnt_nxt = {{(WIDTH-1){1'b0}}, inc_i};
    else if (inc_i && (cnt_r != {WIDTH{1'b1}}))
      cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};  // RULE17
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign count_o = cnt_r;

endmodule : sat_counter

`default_nettype wire

// ===== dv/sdi_rx_error_monitor_properties.sv
/*
  port checker of the receive error monitor.
  assumes it is bound to the monitor's top module.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdi_mon_defs.svh"

module sdi_rx_error_monitor_properties
  import sdi_mon_pkg::*;
#(
  parameter int DATA_WIDTH = 10
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  nrst_i,
  input  wire reg_req_t              reg_req_i,
  input  wire logic [`DATA_W-1:0]    reg_rdata_o,
  input  wire logic                  reg_rvalid_o,
  input  wire rx_evt_t               rx_evt_i,
  input  wire logic                  cdr_locked_i,
  input  wire logic [`RATE_W-1:0]    locked_rate_i,
  input  wire logic [DATA_WIDTH-1:0] rx_data_i,
  input  wire logic                  rx_valid_i,
  input  wire logic [DATA_WIDTH-1:0] parallel_data_outputs_o,
  input  wire logic                  parallel_valid_o,
  input  wire logic                  lock_o,
  input  wire logic                  rx_halted_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_rd(logic [7:0] a);
    reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == a;
  endsequence

  sequence s_pass;
    rx_valid_i && !rx_halted_o;
  endsequence

  sequence s_idle;
    !rx_valid_i || rx_halted_o;
  endsequence

  AST_RVALID: assert property (reg_req_i.rd |=> reg_rvalid_o)
    else $error("read not answered");
  AST_NO_RVALID: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
    else $error("spurious read valid");
  // the rate field is registered, so a read shows the code of the cycle before
  AST_RATE_UNLOCKED: assert property (
    s_rd(`OFS_RATE) ##0 !$past(cdr_locked_i) |=> reg_rdata_o == 8'h70)
    else $error("rate not unlocked code");
  AST_RATE_LOCKED: assert property (
    s_rd(`OFS_RATE) ##0 $past(cdr_locked_i)
      |=> reg_rdata_o[6:4] == $past(locked_rate_i, 2))
    else $error("rate code wrong");
  AST_CFG_RSVD: assert property (
    s_rd(`OFS_EVT_CFG) |=> reg_rdata_o[7:4] == 4'h0)
    else $error("reserved bits set");
  AST_PASS: assert property (s_pass |=> parallel_valid_o
    && parallel_data_outputs_o == $past(rx_data_i))
    else $error("word not passed");
  AST_GATE: assert property (rx_halted_o |=> !parallel_valid_o)
    else $error("data passed while halted");
  AST_HOLD: assert property (s_idle |=>
    $stable(parallel_data_outputs_o))
    else $error("data changed without pass");
  AST_LOCK: assert property (!cdr_locked_i || rx_halted_o |=> !lock_o)
    else $error("lock high while unlocked or halted");
  AST_LOCK_UP: assert property (
    cdr_locked_i && !rx_halted_o && !rx_evt_i.code_err |=> lock_o)
    else $error("lock low while locked and clean");
endmodule : sdi_rx_error_monitor_properties
`default_nettype wire

// ===== dv/sdi_host_model.sv
/*
  host side of the register port: one access per task call.
  assumes requests launch at the falling edge of ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module sdi_host_model
  import sdi_mon_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i,
  output var  reg_req_t   req_o
);
  initial req_o = '0;

  // read data is taken only with its valid, else unknown fails the compare
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge ref_clk_i);
    req_o = {w, ~w, a, d};
    @(negedge ref_clk_i);
    req_o = '0;
    q = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask : access
endmodule : sdi_host_model
`default_nettype wire

// ===== dv/sdi_rx_error_monitor_tb.sv
/*
  directed testbench of the receive error monitor.
  assumes the host model and the property checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdi_mon_defs.svh"

module sdi_rx_error_monitor_tb
  import sdi_mon_pkg::*;
;
  logic       ref_clk_i = 1'b0;
  logic       nrst_i = 1'b0;
  rx_evt_t    evt = '0;
  logic       cdr_locked_i = 1'b0;
  logic [2:0] locked_rate_i = 3'h0;
  logic [9:0] rx_data_i = 10'h2a5;
  logic       rx_valid_i = 1'b0;
  reg_req_t   req;
  logic [7:0] reg_rdata_o;
  logic       reg_rvalid_o;
  logic       pvalid;
  logic       halted;
  logic       lock;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  sdi_host_model u_sdi_host_model (.ref_clk_i, .rvalid_i(reg_rvalid_o),
    .rdata_i(reg_rdata_o), .req_o(req));

  sdi_rx_error_monitor u_sdi_rx_error_monitor (.ref_clk_i, .nrst_i,
    .reg_req_i(req), .reg_rdata_o, .reg_rvalid_o, .rx_evt_i(evt),
    .cdr_locked_i, .locked_rate_i, .rx_data_i, .rx_valid_i,
    .parallel_data_outputs_o(), .parallel_valid_o(pvalid), .lock_o(lock),
    .rx_halted_o(halted));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_sdi_host_model.access(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_sdi_host_model.access(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd

  // event bits: clk, lock, link, code, data, tick
  task automatic pulse(input logic [5:0] e, input int n);
    repeat (n)
    begin
      @(negedge ref_clk_i);
      evt = e;
      @(negedge ref_clk_i);
      evt = '0;
    end
  endtask : pulse

  task automatic word(input logic exp);
    @(negedge ref_clk_i);
    rx_valid_i = 1'b1;
    // a fresh word each call, so a held output can be told from a passed one
    rx_data_i  = ~rx_data_i;
    @(negedge ref_clk_i);
    rx_valid_i = 1'b0;
    chk({7'h0, pvalid}, {7'h0, exp});
  endtask : word

  task automatic t_reset();
    rd(`OFS_THR_LO, 8'h10);
    rd(`OFS_THR_HI, 8'h00);
    wr(`OFS_RATE, 8'h00);
    rd(`OFS_RATE, 8'h70);
    rd(`OFS_EVT_COUNT, 8'h00);
    rd(8'h2c, 8'h00);
  endtask : t_reset

  task automatic t_events();
    pulse(6'h10, 1);
    rd(`OFS_EVT_COUNT, 8'h00);
    wr(`OFS_EVT_CFG, 8'h01);
    pulse(6'h30, 1);
    pulse(6'h10, 1);
    pulse(6'h20, 1);
    pulse(6'h08, 2);
    rd(`OFS_EVT_COUNT, 8'h03);
    wr(`OFS_EVT_CFG, 8'h09);
    rd(`OFS_EVT_COUNT, 8'h02);
    wr(`OFS_EVT_CFG, 8'h0b);
    pulse(6'h08, 1);
    rd(`OFS_EVT_COUNT, 8'h00);
    wr(`OFS_EVT_CFG, 8'h09);
    pulse(6'h08, 300);
    rd(`OFS_EVT_COUNT, 8'hff);
    wr(`OFS_EVT_CFG, 8'h05);
    rd(`OFS_EVT_COUNT, 8'h00);
    wr(`OFS_EVT_CFG, 8'hf5);
    rd(`OFS_EVT_CFG, 8'h05);
  endtask : t_events

  task automatic t_errors();
    wr(`OFS_ERR_MON, 8'h10);
    pulse(6'h02, 2);
    pulse(6'h01, 1);
    rd(`OFS_ERR_CNT_LO, 8'h02);
    rd(`OFS_ERR_CNT_HI, 8'h00);
    wr(`OFS_ERR_MON, 8'h00);
    pulse(6'h01, 1);
    rd(`OFS_ERR_CNT_LO, 8'h00);
    wr(`OFS_ERR_MON, 8'h02);
    rd(`OFS_ERR_CNT_LO, 8'h02);
    wr(`OFS_ERR_MON, 8'h08);
    pulse(6'h04, 1);
    rd(`OFS_ERR_CNT_LO, 8'h00);
    wr(`OFS_ERR_MON, 8'h00);
    pulse(6'h04, 1);
    rd(`OFS_ERR_CNT_LO, 8'h01);
    wr(`OFS_ERR_MON, 8'h06);
    rd(`OFS_ERR_CNT_LO, 8'h00);
    rd(`OFS_ERR_MON, 8'h06);
    wr(`OFS_ERR_MON, 8'h00);
  endtask : t_errors

  task automatic t_rate();
    logic [2:0] codes [3] = '{3'h1, 3'h3, 3'h6};
    cdr_locked_i = 1'b1;
    foreach (codes[i])
    begin
      locked_rate_i = codes[i];
      rd(`OFS_RATE, {1'b0, codes[i], 4'h0});
    end
    chk({7'h0, lock}, 8'h01);
    pulse(6'h04, 1);
    chk({7'h0, lock}, 8'h00);
    wr(`OFS_ERR_MON, 8'h08);
    pulse(6'h04, 1);
    chk({7'h0, lock}, 8'h01);
    wr(`OFS_ERR_MON, 8'h04);
    wr(`OFS_ERR_MON, 8'h00);
    cdr_locked_i = 1'b0;
  endtask : t_rate

  task automatic t_halt();
    wr(`OFS_THR_LO, 8'h02);
    rd(`OFS_THR_LO, 8'h02);
    word(1'b1);
    pulse(6'h02, 3);
    repeat (2) @(negedge ref_clk_i);
    chk({7'h0, halted}, 8'h01);
    word(1'b0);
    wr(`OFS_ERR_MON, 8'h01);
    repeat (2) @(negedge ref_clk_i);
    word(1'b1);
  endtask : t_halt

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      test_done();
    end
  end

  initial
  begin
    repeat (5) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    t_reset();
    t_events();
    t_errors();
    t_rate();
    t_halt();
    test_done();
  end
endmodule : sdi_rx_error_monitor_tb

bind sdi_rx_error_monitor sdi_rx_error_monitor_properties
  #(.DATA_WIDTH(DATA_WIDTH)) u_props (.ref_clk_i, .nrst_i, .reg_req_i,
  .reg_rdata_o, .reg_rvalid_o, .rx_evt_i, .cdr_locked_i, .locked_rate_i,
  .rx_data_i, .rx_valid_i, .parallel_data_outputs_o, .parallel_valid_o,
  .lock_o, .rx_halted_o);
`default_nettype wire
